// ===== ees_seq.sv
// EEPROM command sequencer with AXI4-Lite registers
// Function
// - Erase verify: code 10h, address, word count
// - Blank failure sets both verify bits, then done
// - Erase verify needs parameter index 010
// - Odd address gives access error
// - Command disallowed in mode gives access error
// - Invalid global address gives access error
// - Erase verify range past end: access error
// - Upper bit any fault, lower uncorrectable only
// - Program: code 11h, address, up to four words
// - Launch index sets number of words programmed
// - Program index outside 010..101: access error
// - Program group past end: access error
// - Protected area: no write, protection violation
// - Verify after write; faults set verify bits
// - Sector erase: code 12h, erase then verify
// - Sector erase needs parameter index 001
// - Clearing complete flag launches; set when finished
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`default_nettype none
module ees_seq
  import ees_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ees_fault_s read_fault,
  output logic irq
);
  // Bus slave state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Register file
  logic command_complete_flag_q, command_complete_flag_d;
  logic access_error_flag_q, access_error_flag_d;
  logic protect_violation_flag_q, protect_violation_flag_d;
  logic [1:0] verify_result_bits_q, verify_result_bits_d;
  logic [2:0] parameter_word_index_q, parameter_word_index_d;
  logic [15:0] command_parameter_words_q [NUM_PARAMS];
  logic [15:0] command_parameter_words_d [NUM_PARAMS];
  logic allow_q, allow_d;
  logic [15:0] prot_q, prot_d;
  logic [2:0] ist_q, ist_d, imsk_q, imsk_d;
  logic irq_q, irq_d;
  // Sequencer
  ees_state_e state_q, state_d;
  logic [2:0] lidx_q, lidx_d, wi_q, wi_d, nw_q, nw_d;
  logic [EEP_AW-1:0] ptr_q, ptr_d;
  logic [16:0] cnt_q, cnt_d;
  logic erase_q, erase_d;
  // Combinational helpers
  ees_wr_s mem_wr;
  logic [EEP_AW-1:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic tmr_load, tmr_done;
  logic [15:0] tmr_count;
  logic [31:0] wmask, wval, rd_word;
  logic wr_fire, wr_ok, rd_ok;
  logic [23:0] gaddr, goff;
  logic [EEP_AW-1:0] word, last_word;
  logic in_range, acc, prot_hit, launch;
  logic [2:0] pg_nw, set_ev, clr_ev;
  logic [16:0] span;
  logic [15:0] expect_word;

  ees_mem u_mem (
    .mclk(mclk),
    .wr(mem_wr),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

  ees_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .done_q(tmr_done)
  );

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    command_complete_flag_d = command_complete_flag_q;
    access_error_flag_d = access_error_flag_q;
    protect_violation_flag_d = protect_violation_flag_q;
    verify_result_bits_d = verify_result_bits_q;
    parameter_word_index_d = parameter_word_index_q;
    command_parameter_words_d = command_parameter_words_q;
    allow_d = allow_q;
    prot_d = prot_q;
    imsk_d = imsk_q;
    state_d = state_q;
    lidx_d = lidx_q;
    wi_d = wi_q;
    nw_d = nw_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    erase_d = erase_q;
    mem_wr = '0;
    mem_raddr = ptr_q + {5'h00, wi_q};
    tmr_load = 1'b0;
    tmr_count = PROG_CYC[15:0];
    set_ev = 3'h0;
    clr_ev = 3'h0;
    launch = 1'b0;
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    wr_ok = 1'b1;

    // Write channel: address and data are taken in either order
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end
    wval = w_data_q & wmask;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      case (aw_addr_q)
        ADDR_STATUS: begin
          if (wval[STAT_ACC_ERR]) begin
            access_error_flag_d = 1'b0;
          end
          if (wval[STAT_PROT_ERR]) begin
            protect_violation_flag_d = 1'b0;
          end
          // A launch needs an idle sequencer and each error flag clear or cleared by the same write
          if (wval[STAT_DONE] && command_complete_flag_q
              && (wval[STAT_ACC_ERR] || !access_error_flag_q)
              && (wval[STAT_PROT_ERR] || !protect_violation_flag_q)) begin
            launch = 1'b1;
          end
        end
        ADDR_INDEX: begin
          if (w_strb_q[0]) begin
            parameter_word_index_d = w_data_q[2:0];
          end
        end
        ADDR_PARAM: begin
          // Parameters are frozen while a command runs
          if (command_complete_flag_q && parameter_word_index_q < 3'(NUM_PARAMS)) begin
            command_parameter_words_d[parameter_word_index_q] =
              (command_parameter_words_q[parameter_word_index_q] & ~wmask[15:0])
              | wval[15:0];
          end
        end
        ADDR_CTRL: begin
          if (w_strb_q[0]) begin
            allow_d = w_data_q[0];
          end
        end
        ADDR_PROT: begin
          prot_d = (prot_q & ~wmask[15:0]) | wval[15:0];
        end
        ADDR_IRQ_STAT: begin
          clr_ev = wval[2:0];
        end
        ADDR_IRQ_MASK: begin
          if (w_strb_q[0]) begin
            imsk_d = w_data_q[2:0];
          end
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;

    // Read channel: one read in flight, data one cycle after the address
    case (s_axi_araddr)
      ADDR_STATUS: rd_word = {24'h00_0000, command_complete_flag_q, 1'b0,
        access_error_flag_q, protect_violation_flag_q, 2'b00, verify_result_bits_q};
      ADDR_INDEX: rd_word = {29'h0000_0000, parameter_word_index_q};
      ADDR_PARAM: rd_word = (parameter_word_index_q < 3'(NUM_PARAMS)) ?
        {16'h0000, command_parameter_words_q[parameter_word_index_q]} : 32'h0000_0000;
      ADDR_CTRL: rd_word = {31'h0000_0000, allow_q};
      ADDR_PROT: rd_word = {16'h0000, prot_q};
      ADDR_IRQ_STAT: rd_word = {29'h0000_0000, ist_q};
      ADDR_IRQ_MASK: rd_word = {29'h0000_0000, imsk_q};
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d = rd_ok ? rd_word : 32'h0000_0000;
      rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    arready_d = !rvalid_d;

    // Launch checks on the captured parameters
    gaddr = {command_parameter_words_q[0][7:0], command_parameter_words_q[1]};
    goff = gaddr - EEP_BASE;
    in_range = (gaddr >= EEP_BASE) && (goff < EEP_BYTES);
    word = goff[EEP_AW:1];
    pg_nw = lidx_q - 3'h1;
    span = 17'h00000;
    acc = !allow_q || !in_range || gaddr[0];
    case (command_parameter_words_q[0][15:8])
      CMD_ERASE_VERIFY: begin
        span = {9'h000, word} + {1'b0, command_parameter_words_q[2]};
        acc = acc || (lidx_q != IDX_EV) || (span > EEP_WORDS_17);
      end
      CMD_PROGRAM: begin
        span = {9'h000, word} + {14'h0000, pg_nw};
        acc = acc || (lidx_q < IDX_PG_MIN) || (lidx_q > IDX_PG_MAX)
              || (span > EEP_WORDS_17);
      end
      CMD_ERASE_SECTOR: begin
        span = {9'h000, word} + 17'h00001;
        acc = acc || (lidx_q != IDX_ER);
      end
      default: acc = 1'b1;
    endcase
    // Last word touched decides protection: area from the boundary sector up is locked
    last_word = span[EEP_AW-1:0] - 8'h01;
    prot_hit = prot_q[PROT_EN_BIT] && (last_word[EEP_AW-1:1] >= prot_q[6:0]);
    expect_word = erase_q ? ERASED_WORD : command_parameter_words_q[3'h2 + wi_q];

    case (state_q)
      ST_IDLE: begin
        if (launch) begin
          command_complete_flag_d = 1'b0;
          verify_result_bits_d = 2'b00;
          lidx_d = parameter_word_index_q;
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        wi_d = 3'h0;
        // Refused launches finish here, so no read sees an error flag while busy
        if (acc) begin
          access_error_flag_d = 1'b1;
          command_complete_flag_d = 1'b1;
          set_ev[IRQ_DONE] = 1'b1;
          set_ev[IRQ_ERR] = 1'b1;
          state_d = ST_IDLE;
        end else if (prot_hit
                     && command_parameter_words_q[0][15:8] != CMD_ERASE_VERIFY) begin
          protect_violation_flag_d = 1'b1;
          command_complete_flag_d = 1'b1;
          set_ev[IRQ_DONE] = 1'b1;
          set_ev[IRQ_ERR] = 1'b1;
          state_d = ST_IDLE;
        end else begin
          case (command_parameter_words_q[0][15:8])
            CMD_ERASE_VERIFY: begin
              ptr_d = word;
              cnt_d = {1'b0, command_parameter_words_q[2]};
              state_d = ST_EV_RD;
            end
            CMD_PROGRAM: begin
              ptr_d = word;
              nw_d = pg_nw;
              erase_d = 1'b0;
              state_d = ST_PG_WR;
            end
            default: begin
              ptr_d = {word[EEP_AW-1:1], 1'b0};
              nw_d = SECT_WORDS;
              erase_d = 1'b1;
              state_d = ST_ER_WR;
            end
          endcase
        end
      end
      ST_EV_RD: begin
        mem_raddr = ptr_q;
        state_d = (cnt_q == 17'h00000) ? ST_DONE : ST_EV_CHK;
      end
      ST_EV_CHK: begin
        if (mem_rdata != ERASED_WORD || read_fault.uncorr) begin
          verify_result_bits_d = 2'b11;
        end else if (read_fault.corr) begin
          verify_result_bits_d[1] = 1'b1;
        end
        ptr_d = ptr_q + 8'h01;
        cnt_d = cnt_q - 17'h00001;
        state_d = ST_EV_RD;
      end
      ST_PG_WR: begin
        mem_wr.en = 1'b1;
        mem_wr.addr = ptr_q + {5'h00, wi_q};
        mem_wr.data = command_parameter_words_q[3'h2 + wi_q];
        tmr_load = 1'b1;
        state_d = ST_PG_WAIT;
      end
      ST_PG_WAIT: begin
        if (tmr_done) begin
          wi_d = (wi_q + 3'h1 == nw_q) ? 3'h0 : wi_q + 3'h1;
          state_d = (wi_q + 3'h1 == nw_q) ? ST_VF_RD : ST_PG_WR;
        end
      end
      ST_ER_WR: begin
        mem_wr.en = 1'b1;
        mem_wr.addr = ptr_q + {5'h00, wi_q};
        mem_wr.data = ERASED_WORD;
        if (wi_q + 3'h1 == nw_q) begin
          wi_d = 3'h0;
          tmr_load = 1'b1;
          tmr_count = 16'(ERASE_CYCLES);
          state_d = ST_ER_WAIT;
        end else begin
          wi_d = wi_q + 3'h1;
        end
      end
      ST_ER_WAIT: begin
        if (tmr_done) begin
          state_d = ST_VF_RD;
        end
      end
      ST_VF_RD: begin
        state_d = ST_VF_CHK;
      end
      ST_VF_CHK: begin
        // A mismatch is as bad as an uncorrectable fault
        if (mem_rdata != expect_word || read_fault.uncorr) begin
          verify_result_bits_d = 2'b11;
        end else if (read_fault.corr) begin
          verify_result_bits_d[1] = 1'b1;
        end
        wi_d = wi_q + 3'h1;
        state_d = (wi_q + 3'h1 == nw_q) ? ST_DONE : ST_VF_RD;
      end
      ST_DONE: begin
        command_complete_flag_d = 1'b1;
        set_ev[IRQ_DONE] = 1'b1;
        set_ev[IRQ_ERR] = access_error_flag_q || protect_violation_flag_q;
        set_ev[IRQ_VFAIL] = |verify_result_bits_q;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase

    // A new event wins over a clear in the same cycle
    ist_d = (ist_q & ~clr_ev) | set_ev;
    irq_d = |(ist_d & imsk_d);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      command_complete_flag_q <= DONE_RST;
      access_error_flag_q <= 1'b0;
      protect_violation_flag_q <= 1'b0;
      verify_result_bits_q <= 2'b00;
      parameter_word_index_q <= IDX_RST;
      for (int i = 0; i < NUM_PARAMS; i++) begin
        command_parameter_words_q[i] <= 16'h0000;
      end
      allow_q <= ALLOW_RST;
      prot_q <= PROT_RST;
      ist_q <= 3'h0;
      imsk_q <= MASK_RST;
      irq_q <= 1'b0;
      state_q <= ST_IDLE;
      lidx_q <= 3'h0;
      wi_q <= 3'h0;
      nw_q <= 3'h0;
      ptr_q <= 8'h00;
      cnt_q <= 17'h00000;
      erase_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      command_complete_flag_q <= command_complete_flag_d;
      access_error_flag_q <= access_error_flag_d;
      protect_violation_flag_q <= protect_violation_flag_d;
      verify_result_bits_q <= verify_result_bits_d;
      parameter_word_index_q <= parameter_word_index_d;
      command_parameter_words_q <= command_parameter_words_d;
      allow_q <= allow_d;
      prot_q <= prot_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      irq_q <= irq_d;
      state_q <= state_d;
      lidx_q <= lidx_d;
      wi_q <= wi_d;
      nw_q <= nw_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      erase_q <= erase_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = irq_q;
endmodule : ees_seq
`default_nettype wire

// ===== ees_pkg.sv
// Package with constants and types for the EEPROM command sequencer
`default_nettype none
package ees_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_PARAM = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_PROT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // Status register bit positions
  localparam int STAT_DONE = 7;
  localparam int STAT_ACC_ERR = 5;
  localparam int STAT_PROT_ERR = 4;
  // Interrupt status bit positions, then the protection enable bit
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_VFAIL = 2;
  localparam int PROT_EN_BIT = 15;
  // Reset values
  localparam logic DONE_RST = 1'b1;
  localparam logic ALLOW_RST = 1'b1;
  localparam logic [15:0] PROT_RST = 16'h0000;
  localparam logic [2:0] IDX_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Command codes and required parameter indices
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [2:0] IDX_EV = 3'h2;
  localparam logic [2:0] IDX_PG_MIN = 3'h2;
  localparam logic [2:0] IDX_PG_MAX = 3'h5;
  localparam logic [2:0] IDX_ER = 3'h1;
  localparam int NUM_PARAMS = 6;
  // EEPROM geometry
  localparam logic [23:0] EEP_BASE = 24'h10_0000;
  localparam int EEP_AW = 8;
  localparam int EEP_WORDS = 256;
  localparam logic [16:0] EEP_WORDS_17 = 17'h00100;
  localparam logic [23:0] EEP_BYTES = 24'h00_0200;
  localparam logic [2:0] SECT_WORDS = 3'h2;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_NS = 20000;
  localparam int ERASE_TIME_NS = 25000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    ST_IDLE, ST_CHECK, ST_EV_RD, ST_EV_CHK, ST_PG_WR, ST_PG_WAIT,
    ST_ER_WR, ST_ER_WAIT, ST_VF_RD, ST_VF_CHK, ST_DONE
  } ees_state_e;

  typedef struct packed {
    logic en;
    logic [EEP_AW-1:0] addr;
    logic [15:0] data;
  } ees_wr_s;

  typedef struct packed {
    logic corr;
    logic uncorr;
  } ees_fault_s;
endpackage : ees_pkg
`default_nettype wire

// ===== ees_mem.sv
// Word array holding the EEPROM contents, registered read data
`default_nettype none
module ees_mem
  import ees_pkg::*;
#(
  parameter int DEPTH = EEP_WORDS,
  parameter int AW = EEP_AW
) (
  input wire logic mclk,
  input wire ees_wr_s wr,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata_q
);
  logic [15:0] mem_q [DEPTH];

  // No reset on the array: contents survive a controller reset
  always_ff @(posedge mclk) begin
    if (wr.en) begin
      mem_q[wr.addr] <= wr.data;
    end
    rdata_q <= mem_q[raddr];
  end
endmodule : ees_mem
`default_nettype wire

// ===== ees_timer.sv
// One-shot cycle timer giving a one-cycle done pulse
`default_nettype none
module ees_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] count,
  output logic done_q
);
  logic [15:0] cnt_q, cnt_d;
  logic run_q, run_d, done_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (load) begin
      cnt_d = count;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= 16'h0001) begin
        run_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end
endmodule : ees_timer
`default_nettype wire

// ===== ees_checker.sv
// Bus and status checks for the EEPROM command sequencer
`default_nettype none
module ees_checker
  import ees_pkg::*;
#(
  parameter int ERASE_CYCLES = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ees_fault_s read_fault,
  input wire logic irq
);
  // Read address kept so the answer can be judged by register
  logic [7:0] rd_addr_q;
  logic [7:0] rd_addr_d;
  logic stat_rd;
  always_comb begin
    rd_addr_d = rd_addr_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_d = s_axi_araddr;
    end
  end
  always_ff @(posedge mclk) begin
    rd_addr_q <= rd_addr_d;
  end
  assign stat_rd = s_axi_rvalid && (rd_addr_q == ADDR_STATUS);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_B_LATENCY: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_W_REFUSE: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  AST_R_LATENCY: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_UNMAPPED: assert property (s_axi_rvalid && rd_addr_q > ADDR_IRQ_MASK |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  AST_STAT_RSVD: assert property (stat_rd |-> s_axi_rdata[31:8] == 24'h0 &&
    !s_axi_rdata[6] && s_axi_rdata[3:2] == 2'h0) else $error("status spare bits");
  AST_ERR_DONE: assert property (stat_rd && (s_axi_rdata[STAT_ACC_ERR] ||
    s_axi_rdata[STAT_PROT_ERR]) |-> s_axi_rdata[STAT_DONE]) else $error("error while busy");
  AST_VFY_UPPER: assert property (stat_rd && s_axi_rdata[0] |-> s_axi_rdata[1])
    else $error("lower verify bit alone");
endmodule : ees_checker
`default_nettype wire

// ===== eeprom_command_sequencer_bench.sv
// Self-checking bench for the EEPROM command sequencer
`default_nettype none
module eeprom_command_sequencer_bench
  import ees_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [3:0] idx;
    logic [3:0] mode;
    logic [15:0] w2;
    logic [7:0] exp;
  } ees_row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  ees_fault_s read_fault = 2'b00;
  int fails = 0;
  int n_compared = 0;
  // Mode: [0] uncorrectable, [1] correctable, [2] mode forbids, [3] sectors from 1 protected
  // Programs only ever target words erased by earlier rows
  logic [63:0] rows [28] = '{
    64'h12_100000_10_0000_80, 64'h12_100006_10_0000_80, 64'h12_10000a_10_0000_80,
    64'h10_100000_20_0006_80, 64'h10_100000_30_0001_a0, 64'h10_100001_20_0001_a0,
    64'h10_100000_24_0001_a0, 64'h10_200000_20_0001_a0, 64'h10_1001fc_20_0003_a0,
    64'h11_100008_10_1234_a0, 64'h11_100008_60_1234_a0, 64'h11_1001fe_30_1234_a0,
    64'h12_100000_20_0000_a0, 64'h13_100000_20_0000_a0, 64'h10_100008_20_0002_80,
    64'h11_100008_20_1234_80, 64'h10_10000a_20_0001_80, 64'h10_100008_20_0001_83,
    64'h10_100000_22_0002_82, 64'h10_100000_21_0002_83, 64'h11_100004_28_1234_90,
    64'h12_100004_18_0000_90, 64'h10_100004_28_0002_80, 64'h11_100000_32_aaaa_82,
    64'h12_100002_10_0000_80, 64'h10_100000_20_0002_80, 64'h11_100000_50_0f00_80,
    64'h10_100006_20_0001_83};

  ees_seq #(.ERASE_CYCLES(8)) uut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .read_fault, .irq);

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : axr

  // All six words are loaded every time, so stale words never mask a count slip
  task automatic run(input ees_row_s r);
    logic [15:0] w;
    read_fault <= ees_fault_s'(r.mode[1:0]);
    axw(ADDR_CTRL, {31'h0, !r.mode[2]});
    axw(ADDR_PROT, r.mode[3] ? 32'h8001 : 32'h0);
    for (int i = 0; i < NUM_PARAMS; i++) begin
      w = (i == 0) ? {r.cmd, r.addr[23:16]} : (i == 1) ? r.addr[15:0] : r.w2 + 16'(i - 2);
      axw(ADDR_INDEX, 32'(i));
      axw(ADDR_PARAM, {16'h0, w});
    end
    axw(ADDR_INDEX, {28'h0, r.idx});
    axw(ADDR_STATUS, 32'hb0);
    axr(ADDR_STATUS);
    if (r.cmd == CMD_PROGRAM && r.exp == 8'h80) begin
      check({31'h0, rd[STAT_DONE]}, 32'h0);
    end
    while (rd[STAT_DONE] !== 1'b1) begin
      axr(ADDR_STATUS);
    end
    check(rd, {24'h0, r.exp});
  endtask : run

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int k = 0; k < 28; k++) begin
      run(ees_row_s'(rows[k]));
    end
    axr(ADDR_IRQ_STAT);
    check(rd, 32'h7);
    check({31'h0, irq}, 32'h0);
    axw(ADDR_IRQ_MASK, 32'h2);
    check({31'h0, irq}, 32'h1);
    axw(ADDR_IRQ_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    axr(ADDR_IRQ_STAT);
    check(rd, 32'h5);
    axw(8'h1c, 32'h1);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axr(8'h1c);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axr(ADDR_STATUS);
    check(rd, 32'h80);
    axr(ADDR_CTRL);
    check(rd, 32'h1);
    axr(ADDR_IRQ_MASK);
    check(rd, 32'h0);
    end_sim();
  end

  // Seven programmed words dominate the run; this leaves wide margin
  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    $display("[FAIL] %0t timeout", $time);
    end_sim();
  end
endmodule : eeprom_command_sequencer_bench

bind ees_seq ees_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk (.mclk, .rst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .read_fault, .irq);
`default_nettype wire
